/* File: rtl/cal_regs_pkg.sv */
package cal_regs_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    // Printed offsets are not all multiples of four: they are indices,
    // and the byte address is four times the index.
    localparam logic [7:0]  IDX_STATE      = 8'h6A;
    localparam logic [7:0]  IDX_PIN_SETUP  = 8'h6B;
    localparam logic [7:0]  IDX_SOFT_TRIG  = 8'h6C;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'h70;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h71;
    localparam logic [7:0]  IDX_LP_CTRL    = 8'h72;

    localparam logic [7:0]  PIN_SETUP_RST  = 8'h00;
    localparam logic [7:0]  SOFT_TRIG_RST  = 8'h01;
    localparam logic [7:0]  STATE_RST      = 8'h00;

    // Field positions
    localparam int          FOREGROUND_FINISHED_BIT    = 0;
    localparam int          STOPPED_BIT    = 1;
    localparam int          CODE_LSB       = 2;
    localparam int          CODE_W         = 3;
    localparam int          SRC_SEL_BIT    = 0;
    localparam int          OUT_SEL_LSB    = 1;
    localparam int          SOFT_TRIG_BIT  = 0;
    localparam int          LP_MODE_BIT    = 0;

    // Interrupt status layout
    localparam int          EV_FOREGROUND_FINISHED     = 0;
    localparam int          EV_STOPPED     = 1;
    localparam int          EV_RESUMED     = 2;
    localparam int          EV_W           = 3;

    localparam int          SYNC_STAGES    = 3;

    typedef enum logic [1:0] {
        OUT_FOREGROUND_FINISHED = 2'b00,
        OUT_STOPPED = 2'b01,
        OUT_ALARM   = 2'b10,
        OUT_LOW     = 2'b11
    } out_sel_t;

    typedef struct packed {
        logic                foreground_finished;
        logic                bg_halted;
        logic                bg_running;
        logic                bg_enabled;
        logic [CODE_W-1:0]   code;
    } engine_t;

    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } apb_req_t;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
    import cal_regs_pkg::*;
#(
    parameter int          STAGES  = SYNC_STAGES,
    parameter logic        RST_VAL = 1'b1
) (
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      ce,
    input  wire logic      pin,
    output logic           level
);

    logic [STAGES-1:0]     chain_q;

    if (STAGES < 3) begin : g_too_short
        $error("pin_sync needs at least three stages");
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chain_q <= {STAGES{RST_VAL}};
            level   <= RST_VAL;
        end else if (ce) begin
            chain_q <= {chain_q[STAGES-2:0], pin};
            if (chain_q[STAGES-1] == chain_q[STAGES-2]) begin
                level <= chain_q[STAGES-1];
            end
        end
    end

endmodule

/* File: rtl/apb_slave.sv */
`timescale 1ns/1ps
module apb_slave
    import cal_regs_pkg::*;
(
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output apb_req_t         req,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mapped
);

    // Single-cycle access phase; index is the word address
    always_comb begin
        req.sel   = psel;
        req.en    = psel & penable;
        req.wr    = pwrite;
        req.idx   = paddr[9:2];
        req.wdata = pwdata;
        pready    = 1'b1;
        pslverr   = psel & penable & ~mapped;
    end

endmodule

/* File: rtl/cal_trigger_status.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Contract
// R1: Set background-stopped once background calibration halted at requested phase.
// R2: Clear background-stopped as soon as calibration resumes.
// R3: With background off, set stopped when foreground finished or skipped.
// R4: Foreground-done, bit 0, high once foreground completed or skipped.
// R5: Status register read-only; writes have no effect.
// R6: Two-bit select routes foreground_finished, stopped, alarm, or low to pin.
// R7: Source bit 0 takes software trigger, ignores external pin.
// R8: Source bit 1 takes external pin, ignores software trigger.
// R9: Software trigger bit stands for the pin, resets to one.
// R10: Software without triggers leaves source zero and soft trigger one.
// R11: Software writes reset values into reserved upper bits.
// R12: Trigger low-power mode wakes converter while trigger low.
// R13: External trigger pin synchronised before selection.
// R14: Alarm flag is a single-bit input from outside logic.
module cal_trigger_status
    import cal_regs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        ENG_FOREGROUND_FINISHED,
    input  wire logic        ENG_BG_HALTED,
    input  wire logic        ENG_BG_RUNNING,
    input  wire logic        ENG_BG_ENABLED,
    input  wire logic [2:0]  ENG_CODE,
    input  wire logic        ALARM_IN,
    input  wire logic        TRIGGER_INPUT_PIN,
    output logic             STATE_OUTPUT_PIN,
    output logic             CAL_TRIGGER,
    output logic             CONVERTER_WAKE,
    output logic             IRQ
);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    apb_req_t               req;
    logic                   mapped;
    logic                   wr_en;
    logic                   rd_en;

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == IDX_STATE || idx == IDX_PIN_SETUP || idx == IDX_SOFT_TRIG
            || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK || idx == IDX_LP_CTRL;
    endfunction

    apb_slave u_bus (
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .req     (req),
        .pready  (PREADY),
        .pslverr (PSLVERR),
        .mapped  (mapped)
    );

    assign mapped = is_mapped(req.idx) && PADDR[1:0] == 2'b00 && PADDR[31:10] == '0;
    assign wr_en  = CE & req.en & req.wr & mapped;
    // Read data is loaded on the setup edge so it already stands at the access edge
    assign rd_en  = CE & req.sel & ~req.en & ~req.wr & mapped;

    function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] b);
        return en && a == b;
    endfunction

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0]             pin_setup_q;
    logic [7:0]             soft_trig_q;
    logic                   lp_mode_q;
    logic [EV_W-1:0]        irq_mask_q;

    // Reserved bits are stored as written; software keeps them at reset value
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_setup_q <= PIN_SETUP_RST;
        end else if (hit(wr_en, req.idx, IDX_PIN_SETUP)) begin
            pin_setup_q <= req.wdata[7:0];
        end
    end

    // R9: soft trigger reset one
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            soft_trig_q <= SOFT_TRIG_RST;
        end else if (hit(wr_en, req.idx, IDX_SOFT_TRIG)) begin
            soft_trig_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            lp_mode_q  <= 1'b0;
            irq_mask_q <= '0;
        end else begin
            if (hit(wr_en, req.idx, IDX_LP_CTRL)) begin
                lp_mode_q <= req.wdata[LP_MODE_BIT];
            end
            if (hit(wr_en, req.idx, IDX_IRQ_MASK)) begin
                irq_mask_q <= req.wdata[EV_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Calibration state
    // ****************************************************************
    engine_t                eng;
    logic [7:0]             state_q;
    logic                   stopped_d;

    assign eng = '{foreground_finished: ENG_FOREGROUND_FINISHED, bg_halted: ENG_BG_HALTED,
                   bg_running: ENG_BG_RUNNING, bg_enabled: ENG_BG_ENABLED,
                   code: ENG_CODE};

    always_comb begin
        stopped_d = state_q[STOPPED_BIT];
        // R2: clear on resume
        if (eng.bg_enabled && eng.bg_running) begin
            stopped_d = 1'b0;
        // R1: set on halt
        end else if (eng.bg_enabled && eng.bg_halted) begin
            stopped_d = 1'b1;
        // R3: background off
        end else if (!eng.bg_enabled) begin
            stopped_d = eng.foreground_finished;
        end
    end

    // R5: state register has no write path
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= STATE_RST;
        end else if (CE) begin
            // R4: foreground done bit
            state_q[FOREGROUND_FINISHED_BIT]                 <= eng.foreground_finished;
            state_q[STOPPED_BIT]                 <= stopped_d;
            state_q[CODE_LSB+CODE_W-1:CODE_LSB]  <= eng.code;
            state_q[7:CODE_LSB+CODE_W]           <= '0;
        end
    end

    // ****************************************************************
    // Trigger selection and status pin
    // ****************************************************************
    logic                   ext_trig;
    out_sel_t               out_sel;

    // R13: pin synchroniser
    pin_sync #(
        .STAGES  (SYNC_STAGES),
        .RST_VAL (1'b1)
    ) u_trig_sync (
        .clk   (CLK),
        .nrst  (NRST),
        .ce    (CE),
        .pin   (TRIGGER_INPUT_PIN),
        .level (ext_trig)
    );

    assign out_sel = out_sel_t'(pin_setup_q[OUT_SEL_LSB+1:OUT_SEL_LSB]);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CAL_TRIGGER <= SOFT_TRIG_RST[SOFT_TRIG_BIT];
        end else if (CE) begin
            // R7: software source
            // R8: pin source
            CAL_TRIGGER <= pin_setup_q[SRC_SEL_BIT] ? ext_trig
                                                    : soft_trig_q[SOFT_TRIG_BIT];
        end
    end

    // R12: wake while trigger low
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CONVERTER_WAKE <= 1'b0;
        end else if (CE) begin
            CONVERTER_WAKE <= lp_mode_q & ~CAL_TRIGGER;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            STATE_OUTPUT_PIN <= 1'b0;
        end else if (CE) begin
            // R6: pin routing
            case (out_sel)
                OUT_FOREGROUND_FINISHED: STATE_OUTPUT_PIN <= state_q[FOREGROUND_FINISHED_BIT];
                OUT_STOPPED: STATE_OUTPUT_PIN <= state_q[STOPPED_BIT];
                // R14: alarm input
                OUT_ALARM:   STATE_OUTPUT_PIN <= ALARM_IN;
                default:     STATE_OUTPUT_PIN <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [EV_W-1:0]        irq_stat_q;
    logic [EV_W-1:0]        events;
    logic [EV_W-1:0]        w1c;

    always_comb begin
        events             = '0;
        events[EV_FOREGROUND_FINISHED] = eng.foreground_finished & ~state_q[FOREGROUND_FINISHED_BIT];
        events[EV_STOPPED] = stopped_d & ~state_q[STOPPED_BIT];
        events[EV_RESUMED] = ~stopped_d & state_q[STOPPED_BIT];
        w1c = hit(wr_en, req.idx, IDX_IRQ_STATUS) ? req.wdata[EV_W-1:0] : '0;
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_q <= '0;
        end else if (CE) begin
            irq_stat_q <= (irq_stat_q & ~w1c) | events;
        end
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= '0;
        end else if (rd_en) begin
            case (req.idx)
                IDX_STATE:      PRDATA <= {24'h00_0000, state_q};
                IDX_PIN_SETUP:  PRDATA <= {24'h00_0000, pin_setup_q};
                IDX_SOFT_TRIG:  PRDATA <= {24'h00_0000, soft_trig_q};
                IDX_IRQ_STATUS: PRDATA <= {29'h0000_0000, irq_stat_q};
                IDX_IRQ_MASK:   PRDATA <= {29'h0000_0000, irq_mask_q};
                IDX_LP_CTRL:    PRDATA <= {31'h0000_0000, lp_mode_q};
                default:        PRDATA <= '0;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_state_ro_write: assert property (  // R5
        @(posedge CLK) disable iff (!NRST)
        wr_en && req.idx == IDX_STATE
        |=> state_q[FOREGROUND_FINISHED_BIT] == $past(eng.foreground_finished) && state_q[7:CODE_LSB+CODE_W] == '0)
        else $error("state register changed by write");

    a_foreground_finished_track: assert property (  // R4
        @(posedge CLK) disable iff (!NRST)
        CE && eng.foreground_finished |=> state_q[FOREGROUND_FINISHED_BIT])
        else $error("foreground done not reported");

    a_stop_on_halt: assert property (  // R1
        @(posedge CLK) disable iff (!NRST)
        CE && eng.bg_enabled && eng.bg_halted && !eng.bg_running
        |=> state_q[STOPPED_BIT])
        else $error("stopped bit not set on halt");

    a_clear_on_resume: assert property (  // R2
        @(posedge CLK) disable iff (!NRST)
        CE && eng.bg_enabled && eng.bg_running |=> !state_q[STOPPED_BIT])
        else $error("stopped bit not cleared on resume");

    a_fg_only_stop: assert property (  // R3
        @(posedge CLK) disable iff (!NRST)
        CE && !eng.bg_enabled |=> state_q[STOPPED_BIT] == $past(eng.foreground_finished))
        else $error("stopped bit wrong with background off");

    a_pin_forced_low: assert property (  // R6
        @(posedge CLK) disable iff (!NRST)
        CE && out_sel == OUT_LOW |=> !STATE_OUTPUT_PIN)
        else $error("status pin not low");

    a_pin_alarm: assert property (  // R6
        @(posedge CLK) disable iff (!NRST)
        CE && out_sel == OUT_ALARM |=> STATE_OUTPUT_PIN == $past(ALARM_IN))
        else $error("status pin not alarm");

    a_soft_source: assert property (  // R7
        @(posedge CLK) disable iff (!NRST)
        CE && !pin_setup_q[SRC_SEL_BIT] |=> CAL_TRIGGER == $past(soft_trig_q[0]))
        else $error("software trigger not selected");

    a_pin_source: assert property (  // R8
        @(posedge CLK) disable iff (!NRST)
        CE && pin_setup_q[SRC_SEL_BIT] |=> CAL_TRIGGER == $past(ext_trig))
        else $error("pin trigger not selected");

    a_wake_low: assert property (  // R12
        @(posedge CLK) disable iff (!NRST)
        CE && lp_mode_q && !CAL_TRIGGER |=> CONVERTER_WAKE)
        else $error("converter not woken");

endmodule

/* File: verif/cal_engine_model.sv */
`timescale 1ns/1ps
module cal_engine_model
    import cal_regs_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    nrst,
    input  wire engine_t want,
    input  wire logic    alarm_want,
    input  wire logic    pin_want,
    output engine_t      eng,
    output logic         alarm,
    output logic         pin
);
    // ****************************************************************
    // Engine, alarm and trigger source
    // ****************************************************************
    // Registered so every change lands just after an edge, like real flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eng   <= '0;
            alarm <= 1'b0;
            pin   <= 1'b1;
        end else begin
            eng   <= want;
            alarm <= alarm_want;
            pin   <= pin_want;
        end
    end
endmodule

/* File: verif/test_calibration_trigger_status_regs.sv */
`timescale 1ns/1ps
module test_calibration_trigger_status_regs
    import cal_regs_pkg::*;
;
    logic        clk, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        alarm_want, pin_want, alarm, pin, state_pin, cal_trig, wake, irq;
    engine_t     want, eng;
    int          err_total, checks_done;

    cal_engine_model model (.clk(clk), .nrst(nrst), .want(want), .alarm_want(alarm_want),
        .pin_want(pin_want), .eng(eng), .alarm(alarm), .pin(pin));

    cal_trigger_status uut (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ENG_FOREGROUND_FINISHED(eng.foreground_finished), .ENG_BG_HALTED(eng.bg_halted),
        .ENG_BG_RUNNING(eng.bg_running), .ENG_BG_ENABLED(eng.bg_enabled),
        .ENG_CODE(eng.code), .ALARM_IN(alarm), .TRIGGER_INPUT_PIN(pin),
        .STATE_OUTPUT_PIN(state_pin), .CAL_TRIGGER(cal_trig),
        .CONVERTER_WAKE(wake), .IRQ(irq));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Read data and error are taken at the edge where ready is seen high
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {22'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        er = pslverr;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0000_0000);
        chk(rd, exp, what);
    endtask

    task automatic drive(input engine_t v, input logic a, input logic p);
        @(posedge clk);
        want       <= v;
        alarm_want <= a;
        pin_want   <= p;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic engine_t mk(logic f, logic h, logic r, logic e, logic [2:0] c);
        return '{foreground_finished: f, bg_halted: h, bg_running: r, bg_enabled: e, code: c};
    endfunction

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        int          s;
        int          a;
        logic [31:0] e;
        nrst = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        want = '0;
        alarm_want = 1'b0;
        pin_want = 1'b1;
        err_total = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rdchk(IDX_STATE, 32'h0000_0000, "state reset");
        rdchk(IDX_PIN_SETUP, 32'h0000_0000, "pin setup reset");
        rdchk(IDX_SOFT_TRIG, 32'h0000_0001, "soft trig reset");
        chk(cal_trig, 32'h1, "trigger reset");
        $display("test reset done");
        wr(IDX_IRQ_MASK, 32'h0000_0001);
        drive(mk(1'b1, 1'b0, 1'b0, 1'b0, 3'h5), 1'b0, 1'b1);
        settle(4);
        chk(irq, 32'h1, "irq on foreground_finished");
        rdchk(IDX_STATE, 32'h0000_0017, "foreground_finished, stopped, code");
        rdchk(IDX_IRQ_STATUS, 32'h0000_0003, "events");
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        chk(irq, 32'h0, "irq masked");
        wr(IDX_IRQ_MASK, 32'h0000_0001);
        chk(irq, 32'h1, "irq unmasked");
        wr(IDX_IRQ_STATUS, 32'h0000_0003);
        chk(irq, 32'h0, "irq cleared");
        wr(IDX_STATE, 32'h0000_00FF);
        rdchk(IDX_STATE, 32'h0000_0017, "state write ignored");
        bus(1'b1, 8'h7F, 32'h0000_0000);
        chk(er, 32'h1, "unmapped error");
        $display("test status done");
        drive(mk(1'b1, 1'b0, 1'b1, 1'b1, 3'h0), 1'b0, 1'b1);
        settle(4);
        rdchk(IDX_STATE, 32'h0000_0001, "stopped cleared");
        rdchk(IDX_IRQ_STATUS, 32'h0000_0004, "resume event");
        for (a = 0; a < 2; a++) begin
            for (s = 0; s < 4; s++) begin
                drive(mk(1'b1, 1'b0, 1'b1, 1'b1, 3'h0), a[0], 1'b1);
                wr(IDX_PIN_SETUP, {29'h0, s[1:0], 1'b0});
                settle(3);
                e = (s == 0) ? 32'h1 : (s == 2) ? a : 32'h0;
                chk(state_pin, e, "status pin route");
            end
        end
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b1);
        settle(4);
        rdchk(IDX_STATE, 32'h0000_0003, "stopped set");
        wr(IDX_PIN_SETUP, 32'h0000_0002);
        settle(3);
        chk(state_pin, 32'h1, "pin shows stopped");
        $display("test routing done");
        wr(IDX_PIN_SETUP, 32'h0000_0000);
        wr(IDX_SOFT_TRIG, 32'h0000_0000);
        settle(2);
        chk(cal_trig, 32'h0, "soft trigger low");
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b0);
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b1);
        settle(8);
        chk(cal_trig, 32'h0, "pin ignored");
        wr(IDX_SOFT_TRIG, 32'h0000_0001);
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b0);
        wr(IDX_PIN_SETUP, 32'h0000_0001);
        settle(8);
        chk(cal_trig, 32'h0, "pin selected");
        wr(IDX_SOFT_TRIG, 32'h0000_0000);
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b1);
        settle(2);
        chk(cal_trig, 32'h0, "pin still in sync");
        settle(8);
        chk(cal_trig, 32'h1, "soft ignored");
        wr(IDX_LP_CTRL, 32'h0000_0001);
        settle(2);
        chk(wake, 32'h0, "asleep trigger high");
        drive(mk(1'b1, 1'b1, 1'b0, 1'b1, 3'h0), 1'b0, 1'b0);
        settle(10);
        chk(wake, 32'h1, "awake trigger low");
        $display("test trigger done");
        @(posedge clk);
        ce <= 1'b0;
        wr(IDX_SOFT_TRIG, 32'h0000_0001);
        @(posedge clk);
        ce <= 1'b1;
        rdchk(IDX_SOFT_TRIG, 32'h0000_0000, "write while frozen");
        $display("test enable done");
        conclude();
    end
endmodule
